// ===== hdl/dlsc_pkg.sv
// Purpose: Shared constants and latch function for the dual latch shift cell block
// Assumes: ref_clk at 100 MHz
// Notes:   Timing counts derive from times in ns
package dlsc_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CLOCK_PULSE_NS = 175;
	localparam int SET_PULSE_NS   = 60;
	// Pulse period rounds down, pulse width rounds down
	localparam int CP_CYCLES      = CLOCK_PULSE_NS / CLK_PERIOD_NS;
	localparam int SET_CYCLES     = SET_PULSE_NS / CLK_PERIOD_NS;
	localparam int SET_START      = CP_CYCLES - 2 * SET_CYCLES;
	localparam int HOLD_START     = SET_START + SET_CYCLES;
	localparam int CNT_W          = 5;
	localparam logic [CNT_W-1:0] CNT_LAST  = 5'(CP_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_SET0  = 5'(SET_START);
	localparam logic [CNT_W-1:0] CNT_HOLD0 = 5'(HOLD_START);

	// ----------------------------------------
	// Widths and fields
	// ----------------------------------------
	localparam int WORD_W      = 36;
	localparam int BKP_ADDR_LO = 21;
	localparam int BKP_ADDR_HI = 35;
	localparam int BKP_ADDR_W  = BKP_ADDR_HI - BKP_ADDR_LO + 1;
	localparam int TRIG_TERMS  = 2;
	localparam int TRIG_RESETS = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic              LATCH_RST = 1'b0;
	localparam logic [WORD_W-1:0] WORD_RST  = 36'h0;
	localparam logic [CNT_W-1:0]  CNT_RST   = 5'h0;

	// Set term wins, feedback held unless a reset breaks it
	function automatic logic dlsc_latch_next(input logic on, input logic set, input logic rst);
		dlsc_latch_next = set | (on & ~rst);
	endfunction : dlsc_latch_next

endpackage : dlsc_pkg

// ===== hdl/dlsc_shift_cell.sv
// Purpose: One bit shift cell, two latch stages in series
// Assumes: set_pulse and hold_pulse never overlap
// Notes:   Output moves only on clear or after the hold pulse trails off
`timescale 1ns/10ps
module dlsc_shift_cell
	import dlsc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic nrst,
	input  wire logic clear,
	input  wire logic set_pulse,
	input  wire logic hold_pulse,
	input  wire logic data,
	output logic      q
);

	logic stage1;
	logic hold_d;

	// ----------------------------------------
	// First stage
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			stage1 <= LATCH_RST;
		end else if (clear) begin
			stage1 <= LATCH_RST;
		end else if (set_pulse) begin
			stage1 <= data;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_d <= 1'b0;
		end else begin
			hold_d <= hold_pulse;
		end
	end

	// ----------------------------------------
	// Second stage
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			q <= LATCH_RST;
		end else if (clear) begin
			q <= LATCH_RST;
		end else if (hold_d && !hold_pulse) begin
			q <= stage1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_set_run;
		set_pulse && !clear;
	endsequence

	a_out_steady_set: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_set_run |=> $stable(q) || $past(clear))
		else $error("shift cell output moved during set pulse");

	a_stage1_capture: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_set_run |=> stage1 == $past(data))
		else $error("first stage missed data");

	a_stage1_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
		!set_pulse && !clear |=> $stable(stage1))
		else $error("first stage lost value");

	a_stage2_copy: assert property (@(posedge ref_clk) disable iff (!nrst)
		hold_d && !hold_pulse && !clear |=> q == $past(stage1))
		else $error("second stage did not copy first");

	a_out_trailing: assert property (@(posedge ref_clk) disable iff (!nrst)
		!$stable(q) |-> $past(clear) || ($past(hold_d) && !$past(hold_pulse)))
		else $error("output changed away from trailing edge");

	a_clear_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		clear |=> !q && !stage1)
		else $error("clear did not zero cell");

endmodule : dlsc_shift_cell

// ===== hdl/dlsc_top.sv
// Purpose: Set/reset latches, address-gated backup register and shift cell registers
// Assumes: All inputs come from logic on ref_clk
// Notes:   Set and hold pulses are generated here once per clock pulse
`timescale 1ns/10ps
module dlsc_top
	import dlsc_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    nrst,
	input  wire logic [TRIG_TERMS-1:0]   trig_data,
	input  wire logic [TRIG_TERMS-1:0]   trig_gate,
	input  wire logic [TRIG_RESETS-1:0]  trig_reset,
	output logic                         trig_on,
	output logic                         trig_off,
	input  wire logic                    neg_set_a_n,
	input  wire logic                    neg_set_b_n,
	input  wire logic                    neg_reset_n,
	output logic                         neg_on,
	input  wire logic [WORD_W-1:0]       backup_data,
	input  wire logic                    backup_gate,
	input  wire logic [BKP_ADDR_W-1:0]   backup_addr_data,
	input  wire logic                    backup_addr_gate,
	input  wire logic                    backup_reset,
	output logic [WORD_W-1:0]            backup_q,
	input  wire logic [WORD_W-1:0]       sr_data,
	input  wire logic                    sr_load,
	input  wire logic [WORD_W-1:0]       ac_data,
	input  wire logic                    ac_load,
	input  wire logic [WORD_W-1:0]       quot_data,
	input  wire logic                    quot_load,
	input  wire logic                    reg_clear,
	output logic [WORD_W-1:0]            sr_q,
	output logic [WORD_W-1:0]            ac_q,
	output logic [WORD_W-1:0]            quot_q,
	output logic                         set_pulse,
	output logic                         hold_pulse
);

	logic [CNT_W-1:0] phase;
	logic [CNT_W-1:0] next_phase;
	logic             next_set;
	logic             next_hold;
	logic             ld_sr;
	logic             ld_ac;
	logic             ld_quot;
	logic             trig_set;
	logic             trig_rst;
	logic             neg_set;
	logic             neg_rst;
	logic [WORD_W-1:0] backup_set;

	// ----------------------------------------
	// Clock pulse phase counter
	// ----------------------------------------
	always_comb begin
		if (phase == CNT_LAST) begin
			next_phase = CNT_RST;
		end else begin
			next_phase = phase + 5'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase <= CNT_RST;
		end else begin
			phase <= next_phase;
		end
	end

	// ----------------------------------------
	// Set and hold pulses
	// ----------------------------------------
	always_comb begin
		next_set  = (next_phase >= CNT_SET0) && (next_phase < CNT_HOLD0);
		next_hold = !next_set && (set_pulse || hold_pulse) && (next_phase != CNT_RST);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			set_pulse <= 1'b0;
		end else begin
			set_pulse <= next_set;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_pulse <= 1'b0;
		end else begin
			hold_pulse <= next_hold;
		end
	end

	// ----------------------------------------
	// Register load requests, caught per clock pulse
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ld_sr <= 1'b0;
			ld_ac <= 1'b0;
			ld_quot <= 1'b0;
		end else if (next_phase == CNT_RST) begin
			ld_sr <= sr_load;
			ld_ac <= ac_load;
			ld_quot <= quot_load;
		end
	end

	// ----------------------------------------
	// Shift cell registers
	// ----------------------------------------
	for (genvar i = 0; i < WORD_W; i++) begin : g_cell
		dlsc_shift_cell u_sr (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.clear      (reg_clear),
			.set_pulse  (set_pulse & ld_sr),
			.hold_pulse (hold_pulse & ld_sr),
			.data       (sr_data[i]),
			.q          (sr_q[i])
		);
		dlsc_shift_cell u_ac (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.clear      (reg_clear),
			.set_pulse  (set_pulse & ld_ac),
			.hold_pulse (hold_pulse & ld_ac),
			.data       (ac_data[i]),
			.q          (ac_q[i])
		);
		dlsc_shift_cell u_quot (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.clear      (reg_clear),
			.set_pulse  (set_pulse & ld_quot),
			.hold_pulse (hold_pulse & ld_quot),
			.data       (quot_data[i]),
			.q          (quot_q[i])
		);
	end

	// ----------------------------------------
	// AND-OR-invert latch
	// ----------------------------------------
	always_comb begin
		trig_set = |(trig_data & trig_gate);
		trig_rst = |trig_reset;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			trig_on  <= LATCH_RST;
			trig_off <= !LATCH_RST;
		end else begin
			trig_on  <= dlsc_latch_next(trig_on, trig_set, trig_rst);
			trig_off <= !dlsc_latch_next(trig_on, trig_set, trig_rst);
		end
	end

	// ----------------------------------------
	// Negative-level latch
	// ----------------------------------------
	always_comb begin
		neg_set = !neg_set_a_n || !neg_set_b_n;
		neg_rst = !neg_reset_n;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			neg_on <= LATCH_RST;
		end else begin
			neg_on <= dlsc_latch_next(neg_on, neg_set, neg_rst);
		end
	end

	// ----------------------------------------
	// Instruction backup register
	// ----------------------------------------
	always_comb begin
		backup_set = backup_data & {WORD_W{backup_gate}};
		backup_set[BKP_ADDR_HI:BKP_ADDR_LO] = backup_set[BKP_ADDR_HI:BKP_ADDR_LO]
			| (backup_addr_data & {BKP_ADDR_W{backup_addr_gate}});
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			backup_q <= WORD_RST;
		end else begin
			for (int b = 0; b < WORD_W; b++) begin
				backup_q[b] <= dlsc_latch_next(backup_q[b], backup_set[b], backup_reset);
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_set_rise;
		$rose(set_pulse);
	endsequence

	sequence s_set_body;
		set_pulse [*6] ##1 !set_pulse;
	endsequence

	sequence s_hold_body;
		hold_pulse [*6] ##1 !hold_pulse;
	endsequence

	a_pulse_width: assert property (@(posedge ref_clk) disable iff (!nrst)
		s_set_rise |-> s_set_body)
		else $error("set pulse width wrong");

	a_hold_follows: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(set_pulse) |-> s_hold_body)
		else $error("hold pulse does not follow set");

	a_pulse_excl: assert property (@(posedge ref_clk) disable iff (!nrst)
		!(set_pulse && hold_pulse))
		else $error("set and hold overlap");

	a_pulse_end: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(hold_pulse) |-> phase == CNT_RST ##5 s_set_rise)
		else $error("pulses not at end of clock pulse");

	a_latch_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
		trig_on && !trig_rst |=> trig_on)
		else $error("latch dropped without reset");

	a_latch_sets: assert property (@(posedge ref_clk) disable iff (!nrst)
		trig_set |=> trig_on && !trig_off)
		else $error("latch did not set");

	a_reset_each: assert property (@(posedge ref_clk) disable iff (!nrst)
		(trig_reset[0] || trig_reset[1]) && !trig_set |=> !trig_on && trig_off)
		else $error("single reset did not clear latch");

	a_feedback_keep: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(trig_set) && trig_on && !trig_rst |=> trig_on)
		else $error("feedback did not keep latch");

	a_neg_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
		(!neg_set_a_n || !neg_set_b_n) |=> neg_on)
		else $error("negative latch did not set");

	a_neg_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		!neg_reset_n && neg_set_a_n && neg_set_b_n |=> !neg_on)
		else $error("negative latch did not clear");

	a_backup_addr: assert property (@(posedge ref_clk) disable iff (!nrst)
		backup_addr_gate && backup_addr_data[0] |=> backup_q[BKP_ADDR_LO])
		else $error("address term did not set backup bit");

	a_backup_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		backup_q[BKP_ADDR_HI] && !backup_reset |=> backup_q[BKP_ADDR_HI])
		else $error("backup address bit lost hold");

	a_sr_old_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
		set_pulse && !reg_clear |=> $stable(sr_q) || $past(reg_clear))
		else $error("storage register moved during capture");

	a_ac_old_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
		set_pulse && !reg_clear |=> $stable(ac_q))
		else $error("accumulator moved during capture");

	a_quot_old_kept: assert property (@(posedge ref_clk) disable iff (!nrst)
		set_pulse && !reg_clear |=> $stable(quot_q))
		else $error("quotient register moved during capture");

	a_trig_inverse: assert property (@(posedge ref_clk) disable iff (!nrst)
		trig_off == !trig_on)
		else $error("latch off output not inverse of on");

	a_neg_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
		neg_on && neg_reset_n |=> neg_on)
		else $error("negative latch lost hold");

	a_neg_stays_off: assert property (@(posedge ref_clk) disable iff (!nrst)
		!neg_on && neg_set_a_n && neg_set_b_n |=> !neg_on)
		else $error("negative latch set without source");

	a_backup_data: assert property (@(posedge ref_clk) disable iff (!nrst)
		backup_gate && backup_data[0] |=> backup_q[0])
		else $error("gated data did not set backup bit");

	a_backup_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		backup_reset && !backup_gate && !backup_addr_gate |=> backup_q == WORD_RST)
		else $error("backup reset did not clear register");

	a_phase_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
		phase == CNT_LAST |=> phase == CNT_RST)
		else $error("phase counter did not wrap");

	a_set_phase: assert property (@(posedge ref_clk) disable iff (!nrst)
		set_pulse |-> phase >= CNT_SET0 && phase < CNT_HOLD0)
		else $error("set pulse outside its window");

	a_hold_phase: assert property (@(posedge ref_clk) disable iff (!nrst)
		hold_pulse |-> phase >= CNT_HOLD0)
		else $error("hold pulse outside its window");

	a_hold_rise: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(hold_pulse) |-> phase == CNT_HOLD0)
		else $error("hold pulse rose at wrong phase");

	a_load_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
		next_phase == CNT_RST |=> ld_sr == $past(sr_load))
		else $error("load request not taken at wrap");

	a_clear_regs: assert property (@(posedge ref_clk) disable iff (!nrst)
		reg_clear |=> sr_q == WORD_RST && ac_q == WORD_RST && quot_q == WORD_RST)
		else $error("clear did not zero registers");

	a_out_phase: assert property (@(posedge ref_clk) disable iff (!nrst)
		!$stable(sr_q) |-> $past(phase) == CNT_RST || $past(reg_clear))
		else $error("storage register changed mid pulse");

endmodule : dlsc_top

// ===== dv/dlsc_ctrl_model.sv
// Purpose: Control side model that drives data and load into one shift register
// Assumes: Phase 16 is the sixth cycle of hold_pulse
// Notes:   Data is inverted once the set window has passed
`timescale 1ns/10ps
module dlsc_ctrl_model
	import dlsc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              hold_pulse,
	input  wire logic              req,
	input  wire logic [WORD_W-1:0] val,
	output logic [WORD_W-1:0]      data,
	output logic                   load,
	output logic                   mark
);
	int hc = 0;
	initial begin
		data = 36'h0;
		load = 1'h0;
		mark = 1'h0;
	end
	always @(negedge ref_clk) begin
		hc   <= hold_pulse ? hc + 1 : 0;
		mark <= hold_pulse && hc == 5;
		load <= hold_pulse && hc == 5 && req;
		if (hold_pulse && hc == 5 && req)
			data <= val;
		else if (hold_pulse && hc == 0)
			data <= ~data;
	end
endmodule : dlsc_ctrl_model

// ===== dv/dual_latch_shift_cell_bench.sv
// Purpose: Self-checking bench for latches, backup register and shift cells
// Assumes: Inputs driven on the falling edge
// Notes:   Shift register traffic comes from three control models
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module dual_latch_shift_cell_bench
	import dlsc_pkg::*;
;
	logic                  ref_clk = 1'h0;
	logic                  nrst = 1'h0;
	logic [1:0]            trig_data = 2'h0, trig_gate = 2'h0, trig_reset = 2'h0;
	logic                  trig_on, trig_off, neg_on, set_pulse, hold_pulse;
	logic                  neg_set_a_n = 1'h1, neg_set_b_n = 1'h1, neg_reset_n = 1'h1;
	logic [WORD_W-1:0]     backup_data = 36'h0, backup_q, sr_q, ac_q, quot_q, sr_data, ac_data, quot_data;
	logic                  backup_gate = 1'h0, backup_addr_gate = 1'h0, backup_reset = 1'h0, reg_clear = 1'h0;
	logic [BKP_ADDR_W-1:0] backup_addr_data = 15'h0;
	logic                  sr_load, ac_load, quot_load, sr_mark;
	logic                  sr_req = 1'h0, ac_req = 1'h0, quot_req = 1'h0;
	logic [WORD_W-1:0]     sr_val = 36'h0, ac_val = 36'h0, quot_val = 36'h0, es = 36'h0, ea = 36'h0, em = 36'h0;
	int                    miscompares = 0, n_tests = 0, cycles = 0;
	always #5 ref_clk = ~ref_clk;
	dlsc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .trig_data(trig_data), .trig_gate(trig_gate),
		.trig_reset(trig_reset), .trig_on(trig_on), .trig_off(trig_off), .neg_set_a_n(neg_set_a_n),
		.neg_set_b_n(neg_set_b_n), .neg_reset_n(neg_reset_n), .neg_on(neg_on), .backup_data(backup_data),
		.backup_gate(backup_gate), .backup_addr_data(backup_addr_data), .backup_addr_gate(backup_addr_gate),
		.backup_reset(backup_reset), .backup_q(backup_q), .sr_data(sr_data), .sr_load(sr_load),
		.ac_data(ac_data), .ac_load(ac_load), .quot_data(quot_data), .quot_load(quot_load),
		.reg_clear(reg_clear), .sr_q(sr_q), .ac_q(ac_q), .quot_q(quot_q),
		.set_pulse(set_pulse), .hold_pulse(hold_pulse));
	dlsc_ctrl_model sr_u (.ref_clk(ref_clk), .hold_pulse(hold_pulse), .req(sr_req), .val(sr_val),
		.data(sr_data), .load(sr_load), .mark(sr_mark));
	dlsc_ctrl_model ac_u (.ref_clk(ref_clk), .hold_pulse(hold_pulse), .req(ac_req), .val(ac_val),
		.data(ac_data), .load(ac_load), .mark());
	dlsc_ctrl_model quot_u (.ref_clk(ref_clk), .hold_pulse(hold_pulse), .req(quot_req), .val(quot_val),
		.data(quot_data), .load(quot_load), .mark());

	task automatic tick;
		@(negedge ref_clk);
	endtask : tick

	task automatic report_and_stop;
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			report_and_stop;
		end
	end

	task automatic t_reset;
		repeat (20) tick;
		`CHK({trig_on, trig_off, neg_on, set_pulse, hold_pulse}, 5'h08)
		`CHK({backup_q, sr_q, ac_q, quot_q}, 144'h0)
		nrst = 1'h1;
	endtask : t_reset

	task automatic t_trig;
		trig_data = 2'h1;
		trig_gate = 2'h1;
		tick;
		`CHK({trig_on, trig_off}, 2'h2)
		trig_data = 2'h0;
		repeat (4) tick;
		`CHK(trig_on, 1'h1)
		trig_reset = 2'h2;
		tick;
		`CHK({trig_on, trig_off}, 2'h1)
		trig_reset = 2'h0;
		trig_data = 2'h2;
		tick;
		`CHK(trig_on, 1'h0)
		trig_gate = 2'h2;
		tick;
		trig_gate = 2'h0;
		tick;
		`CHK(trig_on, 1'h1)
		trig_reset = 2'h1;
		tick;
		`CHK(trig_on, 1'h0)
		trig_reset = 2'h0;
	endtask : t_trig

	task automatic t_neg;
		neg_set_a_n = 1'h0;
		tick;
		neg_set_a_n = 1'h1;
		repeat (3) tick;
		`CHK(neg_on, 1'h1)
		neg_reset_n = 1'h0;
		tick;
		neg_reset_n = 1'h1;
		`CHK(neg_on, 1'h0)
		neg_set_b_n = 1'h0;
		tick;
		neg_set_b_n = 1'h1;
		tick;
		`CHK(neg_on, 1'h1)
	endtask : t_neg

	task automatic t_ibr;
		backup_data = 36'hff;
		backup_gate = 1'h1;
		backup_addr_data = 15'h4001;
		tick;
		backup_gate = 1'h0;
		backup_data = 36'hf_ffff_ffff;
		backup_addr_gate = 1'h1;
		tick;
		backup_addr_gate = 1'h0;
		repeat (2) tick;
		`CHK(backup_q, 36'h8_0020_00ff)
		backup_reset = 1'h1;
		tick;
		backup_reset = 1'h0;
		`CHK(backup_q, 36'h0)
	endtask : t_ibr

	task automatic t_pulse;
		int ns, nh, nb;
		ns = 0;
		nh = 0;
		nb = 0;
		repeat (34) begin
			tick;
			ns += int'(set_pulse === 1'h1);
			nh += int'(hold_pulse === 1'h1);
			nb += int'(set_pulse !== 1'h0 && hold_pulse !== 1'h0);
		end
		`CHK(ns, 12)
		`CHK(nh, 12)
		`CHK(nb, 0)
	endtask : t_pulse

	task automatic xfer(input logic [2:0] ld, input logic [WORD_W-1:0] vs, va, vm);
		@(posedge ref_clk iff sr_mark === 1'h1);
		tick;
		{sr_req, ac_req, quot_req} = ld;
		sr_val = vs;
		ac_val = va;
		quot_val = vm;
		@(posedge ref_clk iff sr_mark === 1'h1);
		tick;
		{sr_req, ac_req, quot_req} = 3'h0;
		repeat (17) begin
			tick;
			`CHK({sr_q, ac_q, quot_q}, {es, ea, em})
		end
		tick;
		es = ld[2] ? vs : es;
		ea = ld[1] ? va : ea;
		em = ld[0] ? vm : em;
		`CHK({sr_q, ac_q, quot_q}, {es, ea, em})
	endtask : xfer

	task automatic t_shift;
		xfer(3'h7, 36'hf_ffff_ffff, 36'h5_5555_5555, 36'ha_aaaa_aaaa);
		xfer(3'h4, 36'hf_ffff_ffff, 36'h0, 36'h0);
		xfer(3'h7, 36'h0, 36'h1_2345_6789, 36'hf_ffff_ffff);
		reg_clear = 1'h1;
		tick;
		reg_clear = 1'h0;
		`CHK({sr_q, ac_q, quot_q}, 108'h0)
		es = 36'h0;
		ea = 36'h0;
		em = 36'h0;
		xfer(3'h2, 36'h0, 36'h8_0000_0001, 36'h0);
	endtask : t_shift

	initial begin
		t_reset;
		t_trig;
		t_neg;
		t_ibr;
		t_pulse;
		t_shift;
		report_and_stop;
	end
endmodule : dual_latch_shift_cell_bench
